// File: rtl/rxb_pkg.sv
// Constants and types of the receive buffer manager
package rxb_pkg;
  localparam int unsigned PADDR_W = 8;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_RING_HI = 8'h04;
  localparam logic [7:0] OFS_STAT_HI = 8'h08;
  localparam logic [7:0] OFS_TX_HI = 8'h0c;
  localparam logic [7:0] OFS_RING_START = 8'h10;
  localparam logic [7:0] OFS_RING_END = 8'h14;
  localparam logic [7:0] OFS_RING_WRITE = 8'h18;
  localparam logic [7:0] OFS_RING_READ = 8'h1c;
  localparam logic [7:0] OFS_STAT_CUR = 8'h20;
  localparam logic [7:0] OFS_TX_CUR = 8'h24;
  localparam logic [7:0] OFS_LOW_MARK = 8'h28;
  localparam logic [7:0] OFS_BUF_ADDR0 = 8'h2c;
  localparam logic [7:0] OFS_BUF_ADDR1 = 8'h30;
  localparam logic [7:0] OFS_WORDS_LEFT0 = 8'h34;
  localparam logic [7:0] OFS_WORDS_LEFT1 = 8'h38;
  localparam logic [7:0] OFS_TX_FRAG = 8'h3c;
  localparam logic [7:0] OFS_STATUS = 8'h40;
  // Control field positions
  localparam int unsigned CTRL_RECEIVER_ENABLE_BIT_BIT = 0;
  localparam int unsigned CTRL_WIDE_BIT = 1;
  // Status field positions
  localparam int unsigned STAT_STATE_LSB = 0;
  localparam int unsigned STAT_COUNT_LSB = 4;
  localparam int unsigned STAT_EMPTY_BIT = 12;
  // Reset values
  localparam logic [1:0] RST_CTRL = 2'h0;
  localparam logic [15:0] RST_HALF = 16'h0000;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  // Descriptor geometry: four 16-bit fields per descriptor
  localparam logic [1:0] DESC_LAST_IDX = 2'h3;
  localparam logic [15:0] STEP_NARROW = 16'h0002;
  localparam logic [15:0] STEP_WIDE = 16'h0004;
  localparam logic [15:0] ADV_NARROW = 16'h0008;
  localparam logic [15:0] ADV_WIDE = 16'h0010;
  localparam logic [31:0] DEC_NARROW = 32'h0000_0001;
  localparam logic [31:0] DEC_WIDE = 32'h0000_0002;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_FETCH,
    ST_WAIT,
    ST_STORE,
    ST_WSTAT,
    ST_CHECK
  } rxb_state_t;
endpackage

// File: rtl/rxb_rx_buffer_manager.sv
// Receive descriptor and buffer manager with APB register slave and memory master
`timescale 1ns/1ps
module rxb_rx_buffer_manager (
  input wire logic clk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [rxb_pkg::PADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic pktValid,
  input wire logic [31:0] pktData,
  input wire logic pktLast,
  input wire logic pktMatch,
  input wire logic [15:0] pktStatus,
  input wire logic [15:0] pktByteCount,
  output logic pktReady,
  output logic memReq,
  output logic memWe,
  output logic [31:0] memAddr,
  output logic [31:0] memWdata,
  input wire logic [31:0] memRdata,
  input wire logic memAck,
  output logic [31:0] txDescAddr,
  output logic [31:0] txFragAddr
);
  import rxb_pkg::*;
  logic [1:0] ctrl_ff, nxt_ctrl;
  logic [15:0] ringHi_ff, nxt_ringHi, statHi_ff, nxt_statHi, txHi_ff, nxt_txHi;
  logic [15:0] ringStart_ff, nxt_ringStart, ringEnd_ff, nxt_ringEnd;
  logic [15:0] ringWrite_ff, nxt_ringWrite, ringRead_ff, nxt_ringRead;
  logic [15:0] statCur_ff, nxt_statCur, txCur_ff, nxt_txCur, lowMark_ff, nxt_lowMark;
  logic [31:0] bufAddr_ff, nxt_bufAddr, wordsLeft_ff, nxt_wordsLeft, txFrag_ff, nxt_txFrag;
  logic [31:0] startAddr_ff, nxt_startAddr;
  logic [15:0] pktStat_ff, nxt_pktStat, pktCount_ff, nxt_pktCount, step, adv;
  logic [7:0] doneCnt_ff, nxt_doneCnt;
  rxb_state_t state_ff, nxt_state;
  logic [1:0] idx_ff, nxt_idx;
  logic lastSeen_ff, nxt_lastSeen, empty_ff, nxt_empty, wide, receiver_enable_bit, ack, take;
  logic memReq_ff, nxt_memReq, memWe_ff, nxt_memWe, pktReady_ff, nxt_pktReady;
  logic [31:0] memAddr_ff, nxt_memAddr, memWdata_ff, nxt_memWdata;
  logic [31:0] prdata_ff, nxt_prdata, txDescAddr_ff, nxt_txDescAddr;
  logic pready_ff, nxt_pready, pslverr_ff, nxt_pslverr;
  // Clears the address bits that must be zero for the current bus width
  function automatic logic [15:0] alignOfs(input logic [15:0] ofs, input logic w);
    alignOfs = w ? {ofs[15:2], 2'b00} : {ofs[15:1], 1'b0};
  endfunction

  // Offset sum stays 16 bits so a carry never reaches the base half
  function automatic logic [31:0] descAddr(input logic [15:0] hi, input logic [15:0] ofs,
                                           input logic [1:0] i, input logic w);
    logic [15:0] fieldOfs;
    fieldOfs = w ? {12'h000, i, 2'b00} : {13'h0000, i, 1'b0};
    descAddr = {hi, alignOfs(ofs + fieldOfs, w)};
  endfunction
  assign wide = ctrl_ff[CTRL_WIDE_BIT];
  assign receiver_enable_bit = ctrl_ff[CTRL_RECEIVER_ENABLE_BIT_BIT];
  assign step = wide ? STEP_WIDE : STEP_NARROW;
  assign adv = wide ? ADV_WIDE : ADV_NARROW;
  assign ack = memReq_ff & memAck;
  assign take = pktValid & pktReady_ff;
  always_comb begin
    nxt_ctrl = ctrl_ff;
    nxt_ringHi = ringHi_ff;
    nxt_statHi = statHi_ff;
    nxt_txHi = txHi_ff;
    nxt_ringStart = ringStart_ff;
    nxt_ringEnd = ringEnd_ff;
    nxt_ringWrite = ringWrite_ff;
    nxt_ringRead = ringRead_ff;
    nxt_statCur = statCur_ff;
    nxt_txCur = txCur_ff;
    nxt_lowMark = lowMark_ff;
    nxt_bufAddr = bufAddr_ff;
    nxt_wordsLeft = wordsLeft_ff;
    nxt_txFrag = txFrag_ff;
    nxt_startAddr = startAddr_ff;
    nxt_pktStat = pktStat_ff;
    nxt_pktCount = pktCount_ff;
    nxt_doneCnt = doneCnt_ff;
    nxt_state = state_ff;
    nxt_idx = idx_ff;
    nxt_lastSeen = lastSeen_ff;
    nxt_empty = empty_ff;
    nxt_memReq = memReq_ff;
    nxt_memWe = memWe_ff;
    nxt_memAddr = memAddr_ff;
    nxt_memWdata = memWdata_ff;
    nxt_pktReady = pktReady_ff;
    // Read data is latched in the setup cycle and shown with pready in the access cycle
    nxt_pready = psel & ~penable;
    nxt_pslverr = 1'b0;
    nxt_prdata = RST_WORD;
    if (psel && !penable) begin
      unique case (paddr)
        OFS_CTRL: nxt_prdata = {30'h0, ctrl_ff};
        OFS_RING_HI: nxt_prdata = {16'h0, ringHi_ff};
        OFS_STAT_HI: nxt_prdata = {16'h0, statHi_ff};
        OFS_TX_HI: nxt_prdata = {16'h0, txHi_ff};
        OFS_RING_START: nxt_prdata = {16'h0, ringStart_ff};
        OFS_RING_END: nxt_prdata = {16'h0, ringEnd_ff};
        OFS_RING_WRITE: nxt_prdata = {16'h0, ringWrite_ff};
        OFS_RING_READ: nxt_prdata = {16'h0, ringRead_ff};
        OFS_STAT_CUR: nxt_prdata = {16'h0, statCur_ff};
        OFS_TX_CUR: nxt_prdata = {16'h0, txCur_ff};
        OFS_LOW_MARK: nxt_prdata = {16'h0, lowMark_ff};
        OFS_BUF_ADDR0: nxt_prdata = {16'h0, bufAddr_ff[15:0]};
        OFS_BUF_ADDR1: nxt_prdata = {16'h0, bufAddr_ff[31:16]};
        OFS_WORDS_LEFT0: nxt_prdata = {16'h0, wordsLeft_ff[15:0]};
        OFS_WORDS_LEFT1: nxt_prdata = {16'h0, wordsLeft_ff[31:16]};
        OFS_TX_FRAG: nxt_prdata = txFrag_ff;
        OFS_STATUS: nxt_prdata = {19'h0, empty_ff, doneCnt_ff, 1'b0, state_ff};
        default: nxt_pslverr = 1'b1;
      endcase
    end
    if (psel && penable && pready_ff && pwrite) begin
      unique case (paddr)
        OFS_CTRL: nxt_ctrl = pwdata[1:0];
        OFS_RING_HI: nxt_ringHi = pwdata[15:0];
        OFS_STAT_HI: nxt_statHi = pwdata[15:0];
        OFS_TX_HI: nxt_txHi = pwdata[15:0];
        OFS_RING_START: nxt_ringStart = pwdata[15:0];
        OFS_RING_END: nxt_ringEnd = pwdata[15:0];
        OFS_RING_WRITE: nxt_ringWrite = pwdata[15:0];
        OFS_RING_READ: nxt_ringRead = pwdata[15:0];
        OFS_STAT_CUR: nxt_statCur = pwdata[15:0];
        OFS_TX_CUR: nxt_txCur = pwdata[15:0];
        OFS_LOW_MARK: nxt_lowMark = pwdata[15:0];
        OFS_BUF_ADDR0: nxt_bufAddr[15:0] = pwdata[15:0];
        OFS_BUF_ADDR1: nxt_bufAddr[31:16] = pwdata[15:0];
        OFS_WORDS_LEFT0: nxt_wordsLeft[15:0] = pwdata[15:0];
        OFS_WORDS_LEFT1: nxt_wordsLeft[31:16] = pwdata[15:0];
        OFS_TX_FRAG: nxt_txFrag = pwdata;
        default: ;
      endcase
    end
    // Transmit list pointer; fragment address is passed on without any masking
    nxt_txDescAddr = {txHi_ff, alignOfs(txCur_ff, wide)};
    if (ack) nxt_memReq = 1'b0;
    // Engine updates come last so they win over a simultaneous software write
    unique case (state_ff)
      ST_IDLE: begin
        nxt_pktReady = 1'b0;
        if (receiver_enable_bit) begin
          nxt_state = ST_FETCH;
          nxt_idx = 2'h0;
        end
      end
      ST_FETCH: begin
        if (ack) begin
          unique case (idx_ff)
            2'h0: nxt_bufAddr[15:0] = memRdata[15:0];
            2'h1: nxt_bufAddr[31:16] = memRdata[15:0];
            2'h2: nxt_wordsLeft[15:0] = memRdata[15:0];
            2'h3: nxt_wordsLeft[31:16] = memRdata[15:0];
          endcase
          if (idx_ff == DESC_LAST_IDX) begin
            nxt_ringRead = (ringRead_ff + adv == ringEnd_ff) ? ringStart_ff : ringRead_ff + adv;
            nxt_state = ST_WAIT;
            nxt_pktReady = receiver_enable_bit;
          end else begin
            nxt_idx = idx_ff + 2'h1;
          end
        end else if (!memReq_ff) begin
          // An empty ring stalls here until software adds a descriptor
          nxt_empty = (ringRead_ff == ringWrite_ff);
          if (ringRead_ff != ringWrite_ff) begin
            nxt_memReq = 1'b1;
            nxt_memWe = 1'b0;
            nxt_memAddr = descAddr(ringHi_ff, ringRead_ff, idx_ff, wide);
          end
        end
      end
      ST_WAIT, ST_STORE: begin
        if (ack) begin
          nxt_bufAddr = bufAddr_ff + {16'h0, step};
          nxt_wordsLeft = wordsLeft_ff - (wide ? DEC_WIDE : DEC_NARROW);
          if (lastSeen_ff) begin
            nxt_state = ST_WSTAT;
            nxt_idx = 2'h0;
          end else begin
            nxt_pktReady = 1'b1;
          end
        end else if (state_ff == ST_WAIT && !receiver_enable_bit) begin
          nxt_state = ST_IDLE;
          nxt_pktReady = 1'b0;
        end else if (take && pktMatch && !memReq_ff) begin
          nxt_memReq = 1'b1;
          nxt_memWe = 1'b1;
          nxt_memAddr = {bufAddr_ff[31:16], alignOfs(bufAddr_ff[15:0], wide)};
          nxt_memWdata = wide ? pktData : {16'h0, pktData[15:0]};
          nxt_lastSeen = pktLast;
          nxt_pktReady = 1'b0;
          if (state_ff == ST_WAIT) begin
            nxt_startAddr = bufAddr_ff;
            nxt_state = ST_STORE;
          end
          if (pktLast) begin
            nxt_pktStat = pktStatus;
            nxt_pktCount = pktByteCount;
          end
        end
      end
      ST_WSTAT: begin
        if (ack) begin
          if (idx_ff == DESC_LAST_IDX) begin
            nxt_statCur = statCur_ff + adv;
            nxt_doneCnt = doneCnt_ff + 8'h01;
            nxt_state = ST_CHECK;
          end else begin
            nxt_idx = idx_ff + 2'h1;
          end
        end else if (!memReq_ff) begin
          nxt_memReq = 1'b1;
          nxt_memWe = 1'b1;
          nxt_memAddr = descAddr(statHi_ff, statCur_ff, idx_ff, wide);
          unique case (idx_ff)
            2'h0: nxt_memWdata = {16'h0, pktStat_ff};
            2'h1: nxt_memWdata = {16'h0, pktCount_ff};
            2'h2: nxt_memWdata = {16'h0, startAddr_ff[15:0]};
            2'h3: nxt_memWdata = {16'h0, startAddr_ff[31:16]};
          endcase
        end
      end
      ST_CHECK: begin
        nxt_idx = 2'h0;
        if (wordsLeft_ff < {16'h0, lowMark_ff}) begin
          nxt_state = ST_FETCH;
        end else if (receiver_enable_bit) begin
          nxt_state = ST_WAIT;
          nxt_pktReady = 1'b1;
        end else begin
          nxt_state = ST_IDLE;
        end
      end
    endcase
  end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_ff <= RST_CTRL;
      ringHi_ff <= RST_HALF;
      statHi_ff <= RST_HALF;
      txHi_ff <= RST_HALF;
      ringStart_ff <= RST_HALF;
      ringEnd_ff <= RST_HALF;
      ringWrite_ff <= RST_HALF;
      ringRead_ff <= RST_HALF;
      statCur_ff <= RST_HALF;
      txCur_ff <= RST_HALF;
      lowMark_ff <= RST_HALF;
      bufAddr_ff <= RST_WORD;
      wordsLeft_ff <= RST_WORD;
      txFrag_ff <= RST_WORD;
      startAddr_ff <= RST_WORD;
      pktStat_ff <= RST_HALF;
      pktCount_ff <= RST_HALF;
      doneCnt_ff <= 8'h00;
      state_ff <= ST_IDLE;
      idx_ff <= 2'h0;
      lastSeen_ff <= 1'b0;
      empty_ff <= 1'b0;
      memReq_ff <= 1'b0;
      memWe_ff <= 1'b0;
      memAddr_ff <= RST_WORD;
      memWdata_ff <= RST_WORD;
      pktReady_ff <= 1'b0;
      prdata_ff <= RST_WORD;
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      txDescAddr_ff <= RST_WORD;
    end else begin
      ctrl_ff <= nxt_ctrl;
      ringHi_ff <= nxt_ringHi;
      statHi_ff <= nxt_statHi;
      txHi_ff <= nxt_txHi;
      ringStart_ff <= nxt_ringStart;
      ringEnd_ff <= nxt_ringEnd;
      ringWrite_ff <= nxt_ringWrite;
      ringRead_ff <= nxt_ringRead;
      statCur_ff <= nxt_statCur;
      txCur_ff <= nxt_txCur;
      lowMark_ff <= nxt_lowMark;
      bufAddr_ff <= nxt_bufAddr;
      wordsLeft_ff <= nxt_wordsLeft;
      txFrag_ff <= nxt_txFrag;
      startAddr_ff <= nxt_startAddr;
      pktStat_ff <= nxt_pktStat;
      pktCount_ff <= nxt_pktCount;
      doneCnt_ff <= nxt_doneCnt;
      state_ff <= nxt_state;
      idx_ff <= nxt_idx;
      lastSeen_ff <= nxt_lastSeen;
      empty_ff <= nxt_empty;
      memReq_ff <= nxt_memReq;
      memWe_ff <= nxt_memWe;
      memAddr_ff <= nxt_memAddr;
      memWdata_ff <= nxt_memWdata;
      pktReady_ff <= nxt_pktReady;
      prdata_ff <= nxt_prdata;
      pready_ff <= nxt_pready;
      pslverr_ff <= nxt_pslverr;
      txDescAddr_ff <= nxt_txDescAddr;
    end
  end
  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign pktReady = pktReady_ff;
  assign memReq = memReq_ff;
  assign memWe = memWe_ff;
  assign memAddr = memAddr_ff;
  assign memWdata = memWdata_ff;
  assign txDescAddr = txDescAddr_ff;
  assign txFragAddr = txFrag_ff;
endmodule

// File: sim/rxb_rx_buffer_manager_checker.sv
// Port assertions for the receive buffer manager
`timescale 1ns/1ps
module rxb_rx_buffer_manager_checker (
  input wire logic clk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic pktValid,
  input wire logic pktMatch,
  input wire logic [31:0] pktData,
  input wire logic pktReady,
  input wire logic memReq,
  input wire logic memWe,
  input wire logic [31:0] memAddr,
  input wire logic [31:0] memWdata,
  input wire logic memAck,
  input wire logic [31:0] txDescAddr
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);
  a_access_ready:
    assert property (psel && !penable |=> pready) else $error("no pready in access cycle");
  a_ready_pulse:
    assert property (pready |=> !pready) else $error("pready longer than one cycle");
  a_error_ready:
    assert property (pslverr |-> pready) else $error("pslverr without pready");
  a_mem_hold:
    assert property (memReq && !memAck |=> memReq && $stable(memAddr) && $stable(memWdata) && $stable(memWe))
      else $error("memory request changed before ack");
  a_mem_release:
    assert property (memReq && memAck |=> !memReq) else $error("memory request not released");
  a_word_write:
    assert property (pktValid && pktReady && pktMatch |=> memReq && memWe && !pktReady &&
      memWdata[15:0] == $past(pktData[15:0])) else $error("accepted word not written");
  a_drop_nomatch:
    assert property (pktValid && pktReady && !pktMatch |=> !memReq) else $error("unmatched word written");
  a_ready_idle:
    assert property (pktReady |-> !memReq) else $error("word taken during memory access");
  a_mem_align:
    assert property (memReq |-> !memAddr[0]) else $error("odd memory address");
  a_tx_align:
    assert property (!txDescAddr[0]) else $error("odd transmit descriptor address");
endmodule
bind rxb_rx_buffer_manager rxb_rx_buffer_manager_checker u_rxb_rx_buffer_manager_checker (.clk, .resetn, .psel,
  .penable, .pready, .pslverr, .pktValid, .pktMatch, .pktData, .pktReady, .memReq, .memWe, .memAddr, .memWdata,
  .memAck, .txDescAddr);

// File: sim/rxb_mem_model.sv
// System memory on the far side of the buffer manager
`timescale 1ns/1ps
module rxb_mem_model (
  input wire logic clk,
  input wire logic resetn,
  input wire logic memReq,
  input wire logic memWe,
  input wire logic [31:0] memAddr,
  input wire logic [31:0] memWdata,
  output logic [31:0] memRdata,
  output logic memAck,
  input wire logic [3:0] lat
);
  logic [31:0] mem [logic [31:0]];
  logic [3:0] waitCnt;
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      memAck <= 1'b0;
      waitCnt <= 4'h0;
      memRdata <= 32'h0;
    end else if (memAck) begin
      memAck <= 1'b0;
      // Read data is only good with the ack; scramble it afterwards
      memRdata <= ~memRdata;
    end else if (memReq && waitCnt >= lat) begin
      memAck <= 1'b1;
      waitCnt <= 4'h0;
      if (memWe)
        mem[memAddr] = memWdata;
      else
        memRdata <= mem.exists(memAddr) ? mem[memAddr] : ~memRdata;
    end else if (memReq) begin
      waitCnt <= waitCnt + 4'h1;
    end
  end
endmodule

// File: sim/tb_rxb_rx_buffer_manager.sv
// Self-checking testbench of the receive buffer manager
`timescale 1ns/1ps
`define CHK(g, e, m) begin comparisons++; if ((g) !== (e)) begin errors++; \
  $display("MISMATCH %0t %s got %h exp %h", $time, m, g, e); end end
module tb_rxb_rx_buffer_manager;
  import rxb_pkg::*;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pktValid = 1'b0, pktLast = 1'b0, pktMatch = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, pktData = 32'h0, prdata, memAddr, memWdata, memRdata, txDescAddr, txFragAddr;
  logic pready, pslverr, pktReady, memReq, memWe, memAck;
  logic [15:0] pktStatus = 16'h0, pktByteCount = 16'h0;
  logic [3:0] lat = 4'h0;
  int errors = 0, comparisons = 0;
  always #5 clk = ~clk;
  rxb_rx_buffer_manager u_rxb_rx_buffer_manager (.clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .pktValid, .pktData, .pktLast, .pktMatch, .pktStatus, .pktByteCount, .pktReady,
    .memReq, .memWe, .memAddr, .memWdata, .memRdata, .memAck, .txDescAddr, .txFragAddr);
  rxb_mem_model u_rxb_mem_model (.clk, .resetn, .memReq, .memWe, .memAddr, .memWdata, .memRdata, .memAck, .lat);
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
    output logic e);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // Values read at the edge are those the design sampled there
    do @(posedge clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
    `CHK(e, 1'b0, "write error")
  endtask
  task automatic rdChk(input logic [7:0] a, input logic [15:0] x);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    `CHK(r[15:0], x, "register read")
  endtask
  task automatic memChk(input logic [31:0] a, input logic [15:0] x);
    `CHK(u_rxb_mem_model.mem[a][15:0], x, "memory word")
  endtask
  task automatic putDesc(input logic [31:0] a, input logic [31:0] p, input logic [31:0] wc, input int s);
    // Upper halves carry junk that the engine must ignore
    u_rxb_mem_model.mem[a] = {16'hdead, p[15:0]};
    u_rxb_mem_model.mem[a + s] = {16'hdead, p[31:16]};
    u_rxb_mem_model.mem[a + 2 * s] = {16'hdead, wc[15:0]};
    u_rxb_mem_model.mem[a + 3 * s] = {16'hdead, wc[31:16]};
  endtask
  task automatic sendPkt(input int n, input logic m, input logic [31:0] d);
    for (int i = 0; i < n; i++) begin
      pktValid <= 1'b1;
      pktData <= d + i;
      pktLast <= (i == n - 1);
      pktMatch <= m;
      pktStatus <= 16'h5a00 + 16'(n);
      pktByteCount <= 16'(2 * n);
      do @(posedge clk); while (pktReady !== 1'b1);
    end
    pktValid <= 1'b0;
    pktLast <= 1'b0;
    pktData <= ~pktData;
  endtask
  task automatic waitReady;
    logic [31:0] r;
    logic e;
    do apb(1'b0, OFS_STATUS, 32'h0, r, e); while (r[2:0] !== 3'h2);
  endtask
  task automatic testRegs;
    logic [31:0] r;
    logic e;
    for (int a = 0; a < 16; a++) rdChk(8'(4 * a), 16'h0000);
    apb(1'b0, 8'h44, 32'h0, r, e);
    `CHK({e, r}, 33'h1_0000_0000, "unmapped read")
    apb(1'b1, 8'h48, 32'h1, r, e);
    `CHK(e, 1'b1, "unmapped write")
    wr(OFS_STATUS, 32'hffff_ffff);
    wr(OFS_TX_HI, 32'h0009);
    wr(OFS_TX_CUR, 32'h0033);
    wr(OFS_TX_FRAG, 32'h1234_5677);
    // The write lands on the edge the task returns on; look once it has settled
    @(negedge clk);
    `CHK(txDescAddr, 32'h0009_0032, "tx descriptor address")
    `CHK(txFragAddr, 32'h1234_5677, "tx fragment address")
    $display("test regs done");
  endtask
  task automatic testNarrow;
    putDesc(32'h0001_0110, 32'h0003_1000, 32'h0000_0006, 2);
    putDesc(32'h0001_0100, 32'h0004_1000, 32'h0000_0020, 2);
    wr(OFS_RING_HI, 32'h0001);
    wr(OFS_STAT_HI, 32'h0001);
    wr(OFS_RING_START, 32'h0100);
    wr(OFS_RING_END, 32'h0118);
    wr(OFS_RING_READ, 32'h0110);
    wr(OFS_RING_WRITE, 32'h0108);
    wr(OFS_STAT_CUR, 32'hfff8);
    wr(OFS_LOW_MARK, 32'h0004);
    wr(OFS_CTRL, 32'h0001);
    waitReady;
    rdChk(OFS_BUF_ADDR1, 16'h0003);
    rdChk(OFS_WORDS_LEFT0, 16'h0006);
    rdChk(OFS_RING_READ, 16'h0100);
    sendPkt(2, 1'b1, 32'h0000_a000);
    waitReady;
    rdChk(OFS_BUF_ADDR0, 16'h1004);
    rdChk(OFS_WORDS_LEFT0, 16'h0004);
    sendPkt(3, 1'b0, 32'h0000_c000);
    sendPkt(2, 1'b1, 32'h0000_b000);
    waitReady;
    memChk(32'h0003_1000, 16'ha000);
    memChk(32'h0003_1002, 16'ha001);
    memChk(32'h0003_1004, 16'hb000);
    memChk(32'h0003_1006, 16'hb001);
    memChk(32'h0001_fff8, 16'h5a02);
    memChk(32'h0001_fffa, 16'h0004);
    memChk(32'h0001_fffc, 16'h1000);
    memChk(32'h0001_fffe, 16'h0003);
    memChk(32'h0001_0000, 16'h5a02);
    memChk(32'h0001_0004, 16'h1004);
    `CHK(1'(u_rxb_mem_model.mem.exists(32'h0001_0008)), 1'b0, "status for dropped packet")
    rdChk(OFS_STAT_CUR, 16'h0008);
    rdChk(OFS_STATUS, 16'h0022);
    rdChk(OFS_BUF_ADDR1, 16'h0004);
    rdChk(OFS_WORDS_LEFT0, 16'h0020);
    rdChk(OFS_RING_READ, 16'h0108);
    $display("test narrow done");
  endtask
  task automatic testWide;
    wr(OFS_CTRL, 32'h0000);
    putDesc(32'h0001_0200, 32'h0005_2000, 32'h0000_0010, 4);
    wr(OFS_RING_START, 32'h0200);
    wr(OFS_RING_END, 32'h0300);
    wr(OFS_RING_READ, 32'h0200);
    wr(OFS_RING_WRITE, 32'h0210);
    lat <= 4'h3;
    wr(OFS_CTRL, 32'h0003);
    waitReady;
    sendPkt(2, 1'b1, 32'h7654_3210);
    waitReady;
    `CHK(u_rxb_mem_model.mem[32'h0005_2004], 32'h7654_3211, "wide word")
    memChk(32'h0001_0008, 16'h5a02);
    memChk(32'h0001_0010, 16'h2000);
    memChk(32'h0001_0014, 16'h0005);
    rdChk(OFS_WORDS_LEFT0, 16'h000c);
    rdChk(OFS_STAT_CUR, 16'h0018);
    rdChk(OFS_RING_READ, 16'h0210);
    // Cross the low mark with an empty ring: the fetch must stall and flag it
    wr(OFS_LOW_MARK, 32'h0010);
    sendPkt(2, 1'b1, 32'h0000_e000);
    repeat (80) @(posedge clk);
    memChk(32'h0005_2008, 16'he000);
    memChk(32'h0001_0018, 16'h5a02);
    rdChk(OFS_WORDS_LEFT0, 16'h0008);
    rdChk(OFS_STATUS, 16'h1041);
    rdChk(OFS_RING_READ, 16'h0210);
    $display("test wide done");
  endtask
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    testRegs;
    testNarrow;
    testWide;
    wrap_up;
  end
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    $display("MISMATCH %0t watchdog expired", $time);
    wrap_up;
  end
endmodule
